// ### common/touch_prox_pkg.sv
// Constants, types and decode functions of the fuse configuration block.
// Assumes one 20 MHz clock and a power-on reset for every user.
// What this block does
// R1 - Each fuse bank takes one write only
// R2 - Bank zero bit 7 makes touch toggle
// R3 - Bank zero bit 6 makes proximity latch
// R4 - Bank zero bit 5 sets output polarity
// R5 - Touch threshold field decodes to fractions
// R6 - Proximity threshold field decodes to counts
// R7 - Bank one top bits select halt time
// R8 - Full tuning: low bits give base value
// R9 - Partial tuning: bits 5-4 sensitivity multiplier
// R10 - Partial tuning: bits 3-0 compensation multiplier
// R11 - Programming pin floats outside programming
// R12 - Spare input floats, tie to proximity
// R13 - Bank two bit 2 picks tuning layout
// R14 - Latch holds four seconds, restarts
// R15 - Toggle inverts output on each event
// R16 - Fuses copied to configuration after reset
// R17 - Unprogrammed fuses read zero, code-zero default
package touch_prox_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int BANKS = 3;
  localparam logic [7:0] BANK0_OFFSET = 8'hC4;
  localparam logic [7:0] BANK1_OFFSET = 8'hC5;
  localparam logic [7:0] BANK2_OFFSET = 8'hC6;
  localparam logic [7:0] STATUS_OFFSET = 8'hD0;
  localparam logic [7:0] MASK_OFFSET = 8'hD1;
  localparam logic [7:0] PROGRAMMED_OFFSET = 8'hD2;
  localparam logic [7:0] FUSE_RESET = 8'h00;
  localparam int TOUCH_FUNC_BIT = 7;
  localparam int PROX_FUNC_BIT = 6;
  localparam int POLARITY_BIT = 5;
  localparam int TOUCH_THR_LSB = 2;
  localparam int PROX_THR_LSB = 0;
  localparam int HALT_LSB = 6;
  localparam int BASE_LSB = 0;
  localparam int SENSE_LSB = 4;
  localparam int COMP_LSB = 0;
  localparam int TUNING_SEL_BIT = 2;
  localparam logic TUNING_FULL = 1'b0;
  localparam logic [1:0] HALT_SHORT = 2'b00;
  localparam logic [1:0] HALT_LONG = 2'b01;
  localparam logic [1:0] HALT_NEVER = 2'b10;
  localparam logic [1:0] HALT_ALWAYS = 2'b11;
  localparam int STATUS_W = 4;
  localparam int ST_TOUCH = 0;
  localparam int ST_PROX = 1;
  localparam int ST_PROG = 2;
  localparam int ST_REFUSED = 3;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam int unsigned CLOCK_HZ = 20000000;
  localparam int unsigned LATCH_SECONDS = 4;
  localparam int unsigned HALT_SHORT_SECONDS = 20;
  localparam int unsigned HALT_LONG_SECONDS = 40;
  localparam int unsigned LATCH_CYCLES = LATCH_SECONDS * CLOCK_HZ;
  localparam int unsigned HALT_SHORT_CYCLES = HALT_SHORT_SECONDS * CLOCK_HZ;
  localparam int unsigned HALT_LONG_CYCLES = HALT_LONG_SECONDS * CLOCK_HZ;

  typedef enum logic [1:0] {LOAD = 2'b01, RUN = 2'b10} state_type;

  function automatic logic [7:0] touchThrNum(input logic [2:0] code);
    case (code)
      3'h0: touchThrNum = 8'h48;
      3'h1: touchThrNum = 8'h08;
      3'h2: touchThrNum = 8'h18;
      3'h3: touchThrNum = 8'h30;
      3'h4: touchThrNum = 8'h60;
      3'h5: touchThrNum = 8'h80;
      3'h6: touchThrNum = 8'hA0;
      default: touchThrNum = 8'hC0;
    endcase
  endfunction : touchThrNum

  function automatic logic [4:0] proxThrCount(input logic [1:0] code);
    case (code)
      2'h0: proxThrCount = 5'h04;
      2'h1: proxThrCount = 5'h02;
      2'h2: proxThrCount = 5'h08;
      default: proxThrCount = 5'h10;
    endcase
  endfunction : proxThrCount

  function automatic logic [8:0] baseValue(input logic [2:0] code);
    case (code)
      3'h0: baseValue = 9'h0C8;
      3'h1: baseValue = 9'h032;
      3'h2: baseValue = 9'h04B;
      3'h3: baseValue = 9'h064;
      3'h4: baseValue = 9'h096;
      3'h5: baseValue = 9'h0FA;
      3'h6: baseValue = 9'h12C;
      default: baseValue = 9'h1F4;
    endcase
  endfunction : baseValue
endpackage : touch_prox_pkg

// ### core/output_function.sv
// One sensor output pin: direct, latched or toggled, with polarity.
// Assumes the event input is on clk and config is stable once valid.
`timescale 1ns/1ps
`default_nettype none
module output_function #(
  parameter int unsigned HOLD_CYCLES = touch_prox_pkg::LATCH_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic eventIn,
  input wire logic latchMode,
  input wire logic toggleMode,
  input wire logic activeHigh,
  input wire logic configValid,
  output logic pinLevel
);
  localparam int CNT_W = $clog2(HOLD_CYCLES + 1);

  generate
    if (HOLD_CYCLES < 8)
    begin : holdCheck
      $error("HOLD_CYCLES must be at least 8");
    end
  endgenerate

  logic eventPrev_reg;
  logic toggleState_reg;
  logic [CNT_W-1:0] holdCount_reg;
  logic rise;
  logic actNow;

  assign rise = eventIn & ~eventPrev_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      eventPrev_reg <= 1'b0;
    else
      eventPrev_reg <= eventIn;
  end

  // Hold timer restarts on every new event
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      holdCount_reg <= '0;
    else if (rise)
      holdCount_reg <= CNT_W'(HOLD_CYCLES); // R14
    else if (holdCount_reg != '0)
      holdCount_reg <= holdCount_reg - CNT_W'(1);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      toggleState_reg <= 1'b0;
    else if (rise && toggleMode)
      toggleState_reg <= ~toggleState_reg; // R15
  end

  always_comb
  begin
    if (toggleMode)
      actNow = toggleState_reg ^ rise; // R15
    else if (latchMode)
      actNow = eventIn | (holdCount_reg != '0); // R14
    else
      actNow = eventIn;
  end

  // Idle level before the configuration is loaded is the default low-active
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pinLevel <= 1'b1;
    else if (!configValid)
      pinLevel <= 1'b1;
    else
      pinLevel <= ~(actNow ^ activeHigh); // R4
  end

  sequence riseSeq;
    configValid && rise && !$rose(configValid);
  endsequence

  property toggleFlip;
    @(posedge clk) disable iff (!arst_n)
      riseSeq and toggleMode |=> pinLevel != $past(pinLevel);
  endproperty
  toggle_flip_a: assert property (toggleFlip) // R15
    else $error("toggle output did not invert on event");

  property latchHold;
    @(posedge clk) disable iff (!arst_n)
      riseSeq and latchMode && !toggleMode
        |=> (pinLevel == activeHigh) [*8];
  endproperty
  latch_hold_a: assert property (latchHold) // R14
    else $error("latched output dropped too early");

  property directFollow;
    @(posedge clk) disable iff (!arst_n)
      configValid && !latchMode && !toggleMode
        |=> pinLevel == ~($past(eventIn) ^ $past(activeHigh));
  endproperty
  direct_follow_a: assert property (directFollow) // R4
    else $error("direct output does not follow event");
endmodule : output_function
`default_nettype wire

// ### core/touch_prox_config.sv
// Fuse configuration banks and output logic of the proximity/touch sensor.
// Assumes arst_n is the power-on reset and detect inputs are on clk.
`timescale 1ns/1ps
`default_nettype none
module touch_prox_config #(
  parameter int unsigned LATCH_CYCLES = touch_prox_pkg::LATCH_CYCLES,
  parameter int unsigned HALT_SHORT_CYCLES =
    touch_prox_pkg::HALT_SHORT_CYCLES,
  parameter int unsigned HALT_LONG_CYCLES = touch_prox_pkg::HALT_LONG_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  input wire logic fuseProgramPin,
  input wire logic touchDetect,
  input wire logic proxDetect,
  output logic touchOutput,
  output logic proximityOutput,
  output logic irq,
  output logic configValid,
  output logic fullTuning,
  output logic [7:0] touchThresholdNum,
  output logic [4:0] proxThresholdCount,
  output logic [8:0] baseValue,
  output logic [2:0] sensitivityMultiplier,
  output logic [3:0] compensationMultiplier
);
  localparam int HALT_W = $clog2(HALT_LONG_CYCLES + 1);

  generate
    if (HALT_SHORT_CYCLES < 1 || HALT_SHORT_CYCLES > HALT_LONG_CYCLES)
    begin : haltCheck
      $error("halt cycle counts out of range");
    end
  endgenerate

  logic [7:0] fuseBank_reg [touch_prox_pkg::BANKS];
  logic [touch_prox_pkg::BANKS-1:0] programmed_reg;
  logic [7:0] cfg_reg [touch_prox_pkg::BANKS];
  touch_prox_pkg::state_type state_reg;
  logic progMeta_reg;
  logic progSync_reg;
  logic [touch_prox_pkg::STATUS_W-1:0] status_reg;
  logic [touch_prox_pkg::STATUS_W-1:0] status_next;
  logic [touch_prox_pkg::STATUS_W-1:0] mask_reg;
  logic [HALT_W-1:0] haltCount_reg [2];
  logic [1:0] halted_reg;
  logic [HALT_W-1:0] haltLimit_reg [2];
  logic [1:0] haltOn_reg;
  logic [1:0] qualPrev_reg;
  logic [1:0] rawEvent;
  logic [1:0] qualEvent;
  logic bankHit;
  logic [1:0] bankIdx;
  logic writeOk;
  logic writeRefused;
  logic [1:0] haltCode;

  function automatic logic [1:0] bankIndex(input logic [7:0] a);
    bankIndex = 2'(a - touch_prox_pkg::BANK0_OFFSET);
  endfunction : bankIndex

  function automatic logic isBank(input logic [7:0] a);
    isBank = (a == touch_prox_pkg::BANK0_OFFSET) ||
             (a == touch_prox_pkg::BANK1_OFFSET) ||
             (a == touch_prox_pkg::BANK2_OFFSET);
  endfunction : isBank

  assign bankHit = isBank(addr);
  assign bankIdx = bankIndex(addr);
  assign writeOk = wrStrobe && bankHit && progSync_reg &&
                   !programmed_reg[bankIdx];
  assign writeRefused = wrStrobe && bankHit && !writeOk;
  assign rawEvent = {proxDetect, touchDetect};
  assign qualEvent = rawEvent & ~halted_reg;
  assign haltCode = cfg_reg[1][touch_prox_pkg::HALT_LSB +: 2];

  // Programming pin synchroniser
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      progMeta_reg <= 1'b0;
      progSync_reg <= 1'b0;
    end
    else
    begin
      progMeta_reg <= fuseProgramPin; // R11
      progSync_reg <= progMeta_reg;
    end
  end

  // Fuse banks: one write each, only while the programming pin is high
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < touch_prox_pkg::BANKS; i++)
        fuseBank_reg[i] <= touch_prox_pkg::FUSE_RESET; // R17
      programmed_reg <= '0;
    end
    else if (writeOk)
    begin
      fuseBank_reg[bankIdx] <= wrData; // R1
      programmed_reg[bankIdx] <= 1'b1; // R1
    end
  end

  // Load sequence: copy the fuses once after reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= touch_prox_pkg::LOAD;
      configValid <= 1'b0;
      for (int i = 0; i < touch_prox_pkg::BANKS; i++)
        cfg_reg[i] <= touch_prox_pkg::FUSE_RESET;
    end
    else
    begin
      case (state_reg)
        touch_prox_pkg::LOAD:
        begin
          for (int i = 0; i < touch_prox_pkg::BANKS; i++)
            cfg_reg[i] <= fuseBank_reg[i]; // R16
          configValid <= 1'b1;
          state_reg <= touch_prox_pkg::RUN;
        end
        touch_prox_pkg::RUN:
          configValid <= 1'b1;
        default:
          state_reg <= touch_prox_pkg::LOAD;
      endcase
    end
  end

  // Decoded settings
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fullTuning <= 1'b1;
      touchThresholdNum <= touch_prox_pkg::touchThrNum(3'h0);
      proxThresholdCount <= touch_prox_pkg::proxThrCount(2'h0);
      baseValue <= touch_prox_pkg::baseValue(3'h0);
      sensitivityMultiplier <= 3'h0;
      compensationMultiplier <= 4'h0;
    end
    else
    begin
      fullTuning <= cfg_reg[2][touch_prox_pkg::TUNING_SEL_BIT] ==
                    touch_prox_pkg::TUNING_FULL; // R13
      touchThresholdNum <= touch_prox_pkg::touchThrNum(
        cfg_reg[0][touch_prox_pkg::TOUCH_THR_LSB +: 3]); // R5
      proxThresholdCount <= touch_prox_pkg::proxThrCount(
        cfg_reg[0][touch_prox_pkg::PROX_THR_LSB +: 2]); // R6
      if (cfg_reg[2][touch_prox_pkg::TUNING_SEL_BIT] ==
          touch_prox_pkg::TUNING_FULL)
      begin
        baseValue <= touch_prox_pkg::baseValue(
          cfg_reg[1][touch_prox_pkg::BASE_LSB +: 3]); // R8
        sensitivityMultiplier <= 3'h0;
        compensationMultiplier <= 4'h0;
      end
      else
      begin
        baseValue <= 9'h000;
        sensitivityMultiplier <= {1'b0,
          cfg_reg[1][touch_prox_pkg::SENSE_LSB +: 2]} + 3'h1; // R9
        compensationMultiplier <=
          cfg_reg[1][touch_prox_pkg::COMP_LSB +: 4]; // R10
      end
    end
  end

  // Halt limits per channel: 0 touch, 1 proximity
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      haltOn_reg <= 2'h3;
      haltLimit_reg[0] <= HALT_W'(HALT_SHORT_CYCLES);
      haltLimit_reg[1] <= HALT_W'(HALT_SHORT_CYCLES);
    end
    else
    begin
      case (haltCode)
        touch_prox_pkg::HALT_SHORT:
        begin
          haltOn_reg <= 2'h3; // R7
          haltLimit_reg[0] <= HALT_W'(HALT_SHORT_CYCLES);
          haltLimit_reg[1] <= HALT_W'(HALT_SHORT_CYCLES);
        end
        touch_prox_pkg::HALT_LONG:
        begin
          haltOn_reg <= 2'h3; // R7
          haltLimit_reg[0] <= HALT_W'(HALT_LONG_CYCLES);
          haltLimit_reg[1] <= HALT_W'(HALT_LONG_CYCLES);
        end
        touch_prox_pkg::HALT_NEVER:
        begin
          haltOn_reg <= 2'h0; // R7
          haltLimit_reg[0] <= HALT_W'(HALT_LONG_CYCLES);
          haltLimit_reg[1] <= HALT_W'(HALT_LONG_CYCLES);
        end
        default:
        begin
          haltOn_reg <= 2'h3; // R7
          haltLimit_reg[0] <= HALT_W'(HALT_SHORT_CYCLES);
          haltLimit_reg[1] <= HALT_W'(HALT_LONG_CYCLES);
        end
      endcase
    end
  end

  // Stuck event halting: drop an event held past its limit
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      halted_reg <= 2'h0;
      haltCount_reg[0] <= '0;
      haltCount_reg[1] <= '0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!rawEvent[i] || !configValid)
        begin
          haltCount_reg[i] <= '0;
          halted_reg[i] <= 1'b0;
        end
        else if (haltOn_reg[i] && haltCount_reg[i] >= haltLimit_reg[i])
          halted_reg[i] <= 1'b1; // R7
        else if (!halted_reg[i])
          haltCount_reg[i] <= haltCount_reg[i] + HALT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      qualPrev_reg <= 2'h0;
    else
      qualPrev_reg <= qualEvent;
  end

  // Sticky status: set beats write-one-to-clear
  always_comb
  begin
    status_next = status_reg;
    if (wrStrobe && addr == touch_prox_pkg::STATUS_OFFSET)
      status_next = status_next & ~wrData[touch_prox_pkg::STATUS_W-1:0];
    status_next[touch_prox_pkg::ST_TOUCH] =
      status_next[touch_prox_pkg::ST_TOUCH] | (qualEvent[0] & ~qualPrev_reg[0]);
    status_next[touch_prox_pkg::ST_PROX] =
      status_next[touch_prox_pkg::ST_PROX] | (qualEvent[1] & ~qualPrev_reg[1]);
    status_next[touch_prox_pkg::ST_PROG] =
      status_next[touch_prox_pkg::ST_PROG] | writeOk;
    status_next[touch_prox_pkg::ST_REFUSED] =
      status_next[touch_prox_pkg::ST_REFUSED] | writeRefused;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      status_reg <= touch_prox_pkg::STATUS_RESET;
    else
      status_reg <= status_next;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mask_reg <= touch_prox_pkg::STATUS_RESET;
    else if (wrStrobe && addr == touch_prox_pkg::MASK_OFFSET)
      mask_reg <= wrData[touch_prox_pkg::STATUS_W-1:0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= |(status_reg & mask_reg);
  end

  // Read port: data only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdData <= 8'h00;
    else if (!rdStrobe)
      rdData <= 8'h00;
    else if (bankHit)
      rdData <= fuseBank_reg[bankIdx]; // R17
    else if (addr == touch_prox_pkg::STATUS_OFFSET)
      rdData <= {4'h0, status_reg};
    else if (addr == touch_prox_pkg::MASK_OFFSET)
      rdData <= {4'h0, mask_reg};
    else if (addr == touch_prox_pkg::PROGRAMMED_OFFSET)
      rdData <= {5'h00, programmed_reg};
    else
      rdData <= 8'h00;
  end

  output_function #(
    .HOLD_CYCLES(LATCH_CYCLES)
  ) touchPin (
    .clk(clk),
    .arst_n(arst_n),
    .eventIn(qualEvent[0]),
    .latchMode(1'b0),
    .toggleMode(cfg_reg[0][touch_prox_pkg::TOUCH_FUNC_BIT]), // R2
    .activeHigh(cfg_reg[0][touch_prox_pkg::POLARITY_BIT]), // R4
    .configValid(configValid),
    .pinLevel(touchOutput)
  );

  output_function #(
    .HOLD_CYCLES(LATCH_CYCLES)
  ) proxPin (
    .clk(clk),
    .arst_n(arst_n),
    .eventIn(qualEvent[1]),
    .latchMode(cfg_reg[0][touch_prox_pkg::PROX_FUNC_BIT]), // R3
    .toggleMode(1'b0),
    .activeHigh(cfg_reg[0][touch_prox_pkg::POLARITY_BIT]), // R4
    .configValid(configValid),
    .pinLevel(proximityOutput)
  );

  sequence progDoneSeq;
    wrStrobe && bankHit && programmed_reg[bankIdx];
  endsequence

  property fuseOnce;
    @(posedge clk) disable iff (!arst_n)
      progDoneSeq |=> fuseBank_reg[$past(bankIdx)] ==
        $past(fuseBank_reg[bankIdx]);
  endproperty
  fuse_once_a: assert property (fuseOnce) // R1
    else $error("programmed fuse bank changed");

  property loadCopy;
    @(posedge clk) disable iff (!arst_n)
      state_reg == touch_prox_pkg::LOAD |=>
        configValid && cfg_reg[0] == $past(fuseBank_reg[0]);
  endproperty
  load_copy_a: assert property (loadCopy) // R16
    else $error("configuration not copied from fuses");

  property readBack;
    @(posedge clk) disable iff (!arst_n)
      rdStrobe && addr == touch_prox_pkg::BANK0_OFFSET |=>
        rdData == $past(fuseBank_reg[0]) ##1
          ($past(rdStrobe) || rdData == 8'h00);
  endproperty
  read_back_a: assert property (readBack) // R17
    else $error("fuse read data wrong or held too long");

  property setWins;
    @(posedge clk) disable iff (!arst_n)
      writeOk |=> status_reg[touch_prox_pkg::ST_PROG] ##1 irq ==
        $past(mask_reg[touch_prox_pkg::ST_PROG]) || $past(|status_reg);
  endproperty
  set_wins_a: assert property (setWins)
    else $error("programming flag lost or interrupt wrong");

  property touchThr;
    @(posedge clk) disable iff (!arst_n)
      configValid ##1 $stable(cfg_reg[0]) |=> touchThresholdNum ==
        touch_prox_pkg::touchThrNum(cfg_reg[0][4:2]);
  endproperty
  touch_thr_a: assert property (touchThr) // R5
    else $error("touch threshold decode wrong");

  property proxThr;
    @(posedge clk) disable iff (!arst_n)
      configValid ##1 $stable(cfg_reg[0]) |=> proxThresholdCount ==
        touch_prox_pkg::proxThrCount(cfg_reg[0][1:0]);
  endproperty
  prox_thr_a: assert property (proxThr) // R6
    else $error("proximity threshold decode wrong");

  property tuningLayout;
    @(posedge clk) disable iff (!arst_n)
      configValid ##1 $stable(cfg_reg[2]) ##0 $stable(cfg_reg[1]) |=>
        (fullTuning ? baseValue == touch_prox_pkg::baseValue(cfg_reg[1][2:0])
         : sensitivityMultiplier == {1'b0, cfg_reg[1][5:4]} + 3'h1);
  endproperty
  tuning_layout_a: assert property (tuningLayout) // R13
    else $error("tuning layout decode wrong");

  property neverHalt;
    @(posedge clk) disable iff (!arst_n)
      haltOn_reg == 2'h0 && configValid |=> halted_reg == 2'h0;
  endproperty
  never_halt_a: assert property (neverHalt) // R7
    else $error("event halted while halting disabled");
endmodule : touch_prox_config
`default_nettype wire

// ### testbench/output_host.sv
// Host-side model that samples the touch and proximity pins.
// Assumes both pins are driven on the same clock as the host.
`timescale 1ns/1ps
`default_nettype none
module output_host (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic activeHigh,
  input wire logic touchOutput,
  input wire logic proximityOutput,
  output logic touchOn,
  output logic proxOn,
  output logic [7:0] touchEvents
);
  logic touchOn_reg;
  // Pin level to activity by the programmed polarity
  assign touchOn = touchOutput ~^ activeHigh;
  // Spare input of the host side follows the proximity pin
  assign proxOn = proximityOutput ~^ activeHigh;
  // Counts touch activations seen on the pin
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      touchOn_reg <= 1'b0;
      touchEvents <= 8'h00;
    end
    else
    begin
      touchOn_reg <= touchOn;
      if (touchOn && !touchOn_reg)
        touchEvents <= touchEvents + 8'h01;
    end
  end
endmodule : output_host
`default_nettype wire

// ### testbench/touch_prox_config_tb_top.sv
// Self-checking bench of the fuse configuration block.
// Assumes the package and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    checkCount++; \
    if ((got) !== (ex)) \
    begin \
      failures++; \
      $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module touch_prox_config_tb_top;
  logic clk, arst_n, wrStrobe, rdStrobe, fuseProgramPin;
  logic touchDetect, proxDetect, activeHigh;
  logic [7:0] addr, wrData, rdData, touchThresholdNum, d;
  logic touchOutput, proximityOutput, irq, configValid, fullTuning;
  logic [4:0] proxThresholdCount;
  logic [8:0] baseValue;
  logic [2:0] sensitivityMultiplier;
  logic [3:0] compensationMultiplier;
  logic touchOn, proxOn;
  logic [7:0] touchEvents;
  int failures;
  int checkCount;

  touch_prox_config #(.LATCH_CYCLES(16), .HALT_SHORT_CYCLES(40),
    .HALT_LONG_CYCLES(80)) i_touch_prox_config (.clk(clk),
    .arst_n(arst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .fuseProgramPin(fuseProgramPin),
    .touchDetect(touchDetect), .proxDetect(proxDetect),
    .touchOutput(touchOutput), .proximityOutput(proximityOutput),
    .irq(irq), .configValid(configValid), .fullTuning(fullTuning),
    .touchThresholdNum(touchThresholdNum),
    .proxThresholdCount(proxThresholdCount), .baseValue(baseValue),
    .sensitivityMultiplier(sensitivityMultiplier),
    .compensationMultiplier(compensationMultiplier));

  output_host i_output_host (.clk(clk), .arst_n(arst_n),
    .activeHigh(activeHigh), .touchOutput(touchOutput),
    .proximityOutput(proximityOutput), .touchOn(touchOn), .proxOn(proxOn),
    .touchEvents(touchEvents));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wrData <= v;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    v = rdData;
  endtask : rd

  task automatic doReset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask : doReset

  task automatic defaults();
    `CHK("configValid", 1'b1, configValid)
    `CHK("touchThr", 8'h48, touchThresholdNum)
    `CHK("proxThr", 5'h04, proxThresholdCount)
    `CHK("base", 9'h0C8, baseValue)
    `CHK("fullTuning", 1'b1, fullTuning)
    `CHK("sense", 3'h0, sensitivityMultiplier)
    `CHK("comp", 4'h0, compensationMultiplier)
    `CHK("touchIdle", 1'b1, touchOutput)
    `CHK("proxIdle", 1'b1, proximityOutput)
    rd(8'hC4, d);
    `CHK("bank0", 8'h00, d)
  endtask : defaults

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("[ERR] run expected finish seen timeout");
    summarize();
  end

  initial
  begin
    {arst_n, wrStrobe, rdStrobe, fuseProgramPin} = 4'h0;
    {touchDetect, proxDetect, activeHigh} = 3'h0;
    {addr, wrData} = 16'h0000;
    failures = 0;
    checkCount = 0;
    doReset();
    defaults();
    rd(8'h10, d);
    `CHK("unmapped", 8'h00, d)
    $display("test defaults done");
    // Programming pin left low outside programming
    wr(8'hC4, 8'hA5);
    rd(8'hC4, d);
    `CHK("lockedBank", 8'h00, d)
    rd(8'hD0, d);
    `CHK("refusedFlag", 8'h08, d)
    wr(8'hD0, 8'h0F);
    rd(8'hD0, d);
    `CHK("statusClear", 8'h00, d)
    $display("test refused done");
    fuseProgramPin <= 1'b1;
    repeat (3) @(posedge clk);
    wr(8'hC4, 8'hA5);
    wr(8'hC4, 8'h5A);
    rd(8'hC4, d);
    `CHK("onceBank", 8'hA5, d)
    wr(8'hD2, 8'hFF);
    rd(8'hD2, d);
    `CHK("programmed", 8'h01, d)
    rd(8'hD0, d);
    `CHK("progStatus", 8'h0C, d)
    `CHK("copyOnReset", 8'h48, touchThresholdNum)
    fuseProgramPin <= 1'b0;
    $display("test program done");
    wr(8'hD0, 8'h0F);
    wr(8'hD1, 8'h01);
    touchDetect <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("touchDirect", 1'b0, touchOutput)
    `CHK("hostTouch", 1'b1, touchOn)
    `CHK("irqSet", 1'b1, irq)
    touchDetect <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("touchRelease", 1'b1, touchOutput)
    wr(8'hD0, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("irqClear", 1'b0, irq)
    wr(8'hD1, 8'h00);
    proxDetect <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("proxDirect", 1'b0, proximityOutput)
    `CHK("hostProx", 1'b1, proxOn)
    `CHK("irqMasked", 1'b0, irq)
    proxDetect <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("proxRelease", 1'b1, proximityOutput)
    rd(8'hD0, d);
    `CHK("proxStatus", 8'h02, d)
    $display("test outputs done");
    touchDetect <= 1'b1;
    repeat (30) @(posedge clk);
    `CHK("beforeHalt", 1'b0, touchOutput)
    repeat (20) @(posedge clk);
    `CHK("afterHalt", 1'b1, touchOutput)
    `CHK("hostCount", 8'h02, touchEvents)
    touchDetect <= 1'b0;
    $display("test halt done");
    doReset();
    defaults();
    $display("test second reset done");
    summarize();
  end
endmodule : touch_prox_config_tb_top
`default_nettype wire
